//--- bench/cips_bc_model.sv
// Behavioural BC1.2 analog detector facing the sequencer
`default_nettype none
module cips_bc_model (
   input  wire logic               clk_in,
   input  wire logic               run_in,
   input  wire logic [7:0]         dly_in,
   input  wire cips_pkg::cips_bc_t pick_in,
   output var logic                done_out,
   output cips_pkg::cips_bc_t      result_out
);
   import cips_pkg::*;
   int unsigned cnt_ff = 0;
   // ==============================
   // Answer after dly_in cycles, hold result while done
   initial begin
      done_out = 1'b0;
      result_out = CIPS_BC_UNK;
   end
   // Idle result toggles so a stale value is never mistaken
   always @(posedge clk_in) begin
      if (!run_in) begin
         cnt_ff <= 0;
         done_out <= 1'b0;
         result_out <= cips_bc_t'(~result_out);
      end else if (cnt_ff >= dly_in) begin
         done_out <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 1;
         result_out <= pick_in;
      end
   end
endmodule : cips_bc_model
`default_nettype wire

//--- bench/cips_seq_bench.sv
// Self-checking bench for the input power-up sequencer
`default_nettype none
module cips_seq_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import cips_pkg::*;
   // ==============================
   // Short counts keep the run brief
   localparam int RG = 40, QL = 30, RT = 60, OT = 30, PF = 20;
   logic clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
   logic [3:0] addr_in = 4'h0, vlim_out;
   logic [7:0] wdata_in = 8'h00, rdata_out, dly = 8'h0C;
   logic vin_present_in = 0, vin_awake_in = 0, vin_sleep_in = 0, vin_ov_in = 0;
   logic vin_min_in = 1, bat_otg_ok_in = 0, ts_ok_in = 0, sys_low_in = 0;
   logic bc_done_in, bc_run_out, regulator_on_out, test_load_out, converter_on_out;
   logic boost_on_out, light_load_out, battery_switch_out, boost_2a_out;
   logic vtrack_on_out, host_alert_pulse_out;
   logic [4:0] ilim_eff_out;
   logic [1:0] vlim_os_out, vtrack_sel_out, dplus_drive_out, dminus_drive_out;
   cips_bc_t bc_result_in, pick = CIPS_BC_SDP;
   logic [31:0] seed = 32'h97D1;
   int err_total = 0, n_compared = 0, cyc_cnt = 0, alerts = 0;
   cips_seq #(.CYC_INTERNAL_BIAS_REGULATOR(RG), .CYC_QUAL(QL), .CYC_RETRY(RT), .CYC_OTG(OT),
      .CYC_PFM(PF), .USE_BC12(1'b1)) cips_seq_inst (
      .clk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .vin_present_in, .vin_awake_in, .vin_sleep_in, .vin_ov_in, .vin_min_in,
      .bat_otg_ok_in, .ts_ok_in, .sys_low_in, .bat_below_min_in(1'b0),
      .select_pin_in(1'b0), .bc_done_in, .bc_result_in, .bc_run_out,
      .regulator_on_out, .test_load_out, .converter_on_out, .boost_on_out,
      .light_load_out, .battery_switch_out, .boost_2a_out, .ilim_eff_out,
      .vlim_out, .vlim_os_out, .vtrack_on_out, .vtrack_sel_out,
      .dplus_drive_out, .dminus_drive_out, .host_alert_pulse_out);
   cips_bc_model cips_bc_model_inst (.clk_in, .run_in(bc_run_out), .dly_in(dly),
      .pick_in(pick), .done_out(bc_done_in), .result_out(bc_result_in));
   // ==============================
   // Clock, cycle ceiling, alert count
   always #50 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc_cnt++;
      if (host_alert_pulse_out === 1'b1) alerts++;
      if (cyc_cnt == 20000) begin
         err_total++;
         end_of_test();
      end
   end
   // ==============================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Expected {source code, limit code} per detector result
   function automatic logic [7:0] exp_lim(input int r);
      case (r)
         0: return 8'h24;
         1: return 8'h6E;
         2: return 8'h97;
         3: return 8'hD4;
         4: return 8'hD3;
         5: return 8'hC9;
         6: return 8'hD7;
         default: return 8'hA4;
      endcase
   endfunction : exp_lim
   function automatic logic sig(input int s);
      case (s)
         0: return regulator_on_out;
         1: return converter_on_out;
         2: return bc_run_out;
         3: return boost_on_out;
         default: return test_load_out;
      endcase
   endfunction : sig
   task automatic wt(input int s, input logic v, output int n);
      n = 0;
      while (sig(s) !== v && n < 5000) begin
         @(posedge clk_in);
         #1;
         n++;
      end
   endtask : wt
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      d = rdata_out;
   endtask : rd
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   task automatic chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h00, e}, {7'h00, g});
   endtask : chk1
   task automatic end_of_test();
      if (err_total == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // ==============================
   // Main sequence
   initial begin : main
      int n, m, r, k, a0;
      logic [7:0] d, v, e;
      logic [3:0] ra [4];
      logic [7:0] rv [4];
      ra = '{4'h0, 4'h1, 4'h2, 4'h9};
      rv = '{8'h24, 8'h06, 8'h04, 8'h00};
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      chk1("bsw_rst", 1'b1, battery_switch_out);
      foreach (ra[i]) begin
         rd(ra[i], d);
         chk8("reset_value", rv[i], d);
      end
      for (k = 0; k < 6; k++) begin
         v = (k == 0) ? 8'h40 : 8'(rnd());
         wr(4'h1, v);
         rd(4'h1, d);
         chk8("vlim_rd", v, d);
         chk8("vlim_pins", v, {vtrack_sel_out, vlim_os_out, vlim_out});
         chk1("track_on", v[7:6] != 2'h0 && v[5:4] == 2'h0, vtrack_on_out);
      end
      wr(4'h1, 8'h06);
      for (r = 0; r < 8; r++) begin
         a0 = alerts;
         e = exp_lim(r);
         @(posedge clk_in);
         pick <= cips_bc_t'(r);
         dly <= 8'(rnd() % 16) + 8'h0C;
         vin_ov_in <= (r == 0);
         vin_present_in <= 1'b1;
         vin_awake_in <= 1'b1;
         // First attach: one-cycle dropout restarts the wait
         if (r == 0) begin
            repeat (20) @(posedge clk_in);
            vin_present_in <= 1'b0;
            @(posedge clk_in);
            vin_present_in <= 1'b1;
         end
         wt(0, 1'b1, n);
         chk1("internal_bias_regulator_wait", 1'b1, n >= RG && n <= RG + 5);
         if (r == 0) begin
            wt(4, 1'b0, n);
            chk1("qual_abort", 1'b1, n < QL);
            @(posedge clk_in);
            vin_ov_in <= 1'b0;
            wt(4, 1'b1, m);
            chk1("retry_gap", 1'b1, m >= RT - 2 && m <= RT + 4);
         end
         wt(4, 1'b0, n);
         chk1("qual_len", 1'b1, n >= QL - 2 && n <= QL + 1);
         wt(2, 1'b1, n);
         rd(4'h4, d);
         chk8("stat_good", 8'h40, d & 8'hC0);
         v = 8'(rnd()) | 8'h05;
         wr(4'h3, v);
         #1;
         chk8("drv_quiet", 8'h00, {4'h0, dminus_drive_out, dplus_drive_out});
         wt(1, 1'b1, n);
         rd(4'h2, d);
         chk8("ilim_det", {3'h0, e[4:0]}, d);
         rd(4'h4, d);
         chk8("stat_done", {3'h6, e[7:5], 2'h0}, d & 8'hFC);
         chk8("alerts", 8'h02, 8'(alerts - a0));
         chk8("drv_host", {4'h0, v[3:0]}, {4'h0, dminus_drive_out, dplus_drive_out});
         // Host overwrite, low system cap, forced detection
         if (r == 7) begin
            wr(4'h2, 8'h0A);
            rd(4'h5, d);
            chk8("ilim_host", 8'h0A, d);
            @(posedge clk_in);
            sys_low_in <= 1'b1;
            repeat (6) @(posedge clk_in);
            #1;
            chk8("ilim_cap", 8'h01, {3'h0, ilim_eff_out});
            @(posedge clk_in);
            sys_low_in <= 1'b0;
            wr(4'h0, 8'h03);
            wt(2, 1'b1, n);
            wt(2, 1'b0, n);
            repeat (3) @(posedge clk_in);
            rd(4'h0, d);
            chk8("force_clr", 8'h01, d);
            chk1("bsw_off", 1'b0, battery_switch_out);
            chk1("light_on", 1'b1, light_load_out);
            rd(4'h2, d);
            chk8("ilim_reload", 8'h04, d);
         end
         @(posedge clk_in);
         vin_present_in <= 1'b0;
         wt(0, 1'b0, n);
      end
      @(posedge clk_in);
      vin_awake_in <= 1'b0;
      vin_sleep_in <= 1'b1;
      bat_otg_ok_in <= 1'b1;
      ts_ok_in <= 1'b1;
      wr(4'h0, 8'h10);
      wt(3, 1'b1, n);
      chk1("otg_wait", 1'b1, n >= OT - 2 && n <= OT + 6);
      rd(4'h4, d);
      chk8("src_otg", 8'h1C, d & 8'h1C);
      chk1("pfm_start", 1'b1, light_load_out);
      chk1("boost_current_select", 1'b0, boost_2a_out);
      repeat (PF + 4) @(posedge clk_in);
      #1;
      chk1("pfm_end", 1'b0, light_load_out);
      wr(4'h0, 8'h30);
      #1;
      chk1("boost_2a", 1'b1, boost_2a_out);
      wr(4'h0, 8'h00);
      wt(3, 1'b0, n);
      chk1("boost_exit", 1'b1, n <= 5);
      end_of_test();
   end
endmodule : cips_seq_bench
bind cips_seq cips_seq_monitor #(.CYC_INTERNAL_BIAS_REGULATOR(CYC_INTERNAL_BIAS_REGULATOR), .CYC_QUAL(CYC_QUAL)) cips_seq_monitor_inst (
   .clk_in, .reset_in, .vin_present_in, .vin_awake_in, .vin_sleep_in, .bat_otg_ok_in,
   .ts_ok_in, .sys_low_in, .bc_run_out, .regulator_on_out, .test_load_out,
   .converter_on_out, .boost_on_out, .ilim_eff_out, .dplus_drive_out,
   .dminus_drive_out, .host_alert_pulse_out);
`default_nettype wire

//--- bench/cips_seq_monitor.sv
// Port checker for the input power-up sequencer
`default_nettype none
module cips_seq_monitor #(
   parameter int unsigned CYC_INTERNAL_BIAS_REGULATOR = 40,
   parameter int unsigned CYC_QUAL = 30
) (
   input wire logic       clk_in,
   input wire logic       reset_in,
   input wire logic       vin_present_in,
   input wire logic       vin_awake_in,
   input wire logic       vin_sleep_in,
   input wire logic       bat_otg_ok_in,
   input wire logic       ts_ok_in,
   input wire logic       sys_low_in,
   input wire logic       bc_run_out,
   input wire logic       regulator_on_out,
   input wire logic       test_load_out,
   input wire logic       converter_on_out,
   input wire logic       boost_on_out,
   input wire logic [4:0] ilim_eff_out,
   input wire logic [1:0] dplus_drive_out,
   input wire logic [1:0] dminus_drive_out,
   input wire logic       host_alert_pulse_out
);
   // ==============================
   // Run-length counters
   int unsigned pa_ff, ld_ff;
   // Raw inputs counted, so sync latency only adds margin
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pa_ff <= 0;
         ld_ff <= 0;
      end else begin
         pa_ff <= (vin_present_in && vin_awake_in) ? pa_ff + 1 : 0;
         ld_ff <= test_load_out ? ld_ff + 1 : 0;
      end
   end
   // ==============================
   // Assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   a_internal_bias_regulator_hold: assert property ($rose(regulator_on_out) |-> pa_ff >= CYC_INTERNAL_BIAS_REGULATOR)
      else $error("regulator on early");
   a_qual_len: assert property (ld_ff <= CYC_QUAL + 1)
      else $error("test load too long");
   a_alert_gap: assert property (host_alert_pulse_out |=> !host_alert_pulse_out)
      else $error("alert pulse too long");
   a_detect_cond: assert property ($rose(bc_run_out) |-> regulator_on_out && !test_load_out)
      else $error("detection out of order");
   a_drive_quiet: assert property (bc_run_out && $past(bc_run_out) |->
      dplus_drive_out == 2'h0 && dminus_drive_out == 2'h0)
      else $error("line drive during detection");
   a_sys_cap: assert property (sys_low_in [*4] ##0 converter_on_out |->
      ilim_eff_out <= 5'h01)
      else $error("current not capped");
   a_conv_order: assert property ($rose(converter_on_out) |->
      regulator_on_out && !test_load_out && !bc_run_out)
      else $error("converter started early");
   a_boost_entry: assert property ($rose(boost_on_out) |-> $past(vin_sleep_in, 3) &&
      $past(bat_otg_ok_in, 3) && $past(ts_ok_in, 3))
      else $error("boost entry unqualified");
endmodule : cips_seq_monitor
`default_nettype wire

//--- design/cips_cfg.svh
// Constants for the charger input power-up sequencer
`ifndef CIPS_CFG_SVH
`define CIPS_CFG_SVH

// ==============================
// Clock and timing
`define CIPS_CLK_HZ         10000000
`define CIPS_MS_CYC         (`CIPS_CLK_HZ / 1000)
`define CIPS_T_INTERNAL_BIAS_REGULATOR_MS      220
`define CIPS_T_QUAL_MS      30
`define CIPS_T_RETRY_MS     2000
`define CIPS_T_OTG_MS       30
`define CIPS_T_PFM_MS       1
`define CIPS_CYC_INTERNAL_BIAS_REGULATOR       (`CIPS_T_INTERNAL_BIAS_REGULATOR_MS * `CIPS_MS_CYC)
`define CIPS_CYC_QUAL       (`CIPS_T_QUAL_MS * `CIPS_MS_CYC)
`define CIPS_CYC_RETRY      (`CIPS_T_RETRY_MS * `CIPS_MS_CYC)
`define CIPS_CYC_OTG        (`CIPS_T_OTG_MS * `CIPS_MS_CYC)
`define CIPS_CYC_PFM        (`CIPS_T_PFM_MS * `CIPS_MS_CYC)

// ==============================
// Register map
`define CIPS_ADDR_CTRL      4'h0
`define CIPS_ADDR_VLIM      4'h1
`define CIPS_ADDR_ILIM      4'h2
`define CIPS_ADDR_DPDM      4'h3
`define CIPS_ADDR_STAT      4'h4
`define CIPS_ADDR_VEFF      4'h5

// CTRL bit positions
`define CIPS_B_HOSTMODE     0
`define CIPS_B_FORCEDET     1
`define CIPS_B_CHGEN        2
`define CIPS_B_PFMBLK       3
`define CIPS_B_OTGEN        4
`define CIPS_B_BOOSTSEL     5

// ==============================
// Codes and reset values
`define CIPS_ILIM_200MA     5'h01
`define CIPS_ILIM_500MA     5'h04
`define CIPS_ILIM_1000MA    5'h09
`define CIPS_ILIM_1500MA    5'h0E
`define CIPS_ILIM_2000MA    5'h13
`define CIPS_ILIM_2100MA    5'h14
`define CIPS_ILIM_2400MA    5'h17
`define CIPS_VLIM_RST       4'h6
`define CIPS_VOS_RST        2'h0
`define CIPS_SRC_NONE       3'h0
`define CIPS_SRC_SDP        3'h1
`define CIPS_SRC_ADAPT      3'h2
`define CIPS_SRC_CDP        3'h3
`define CIPS_SRC_DCP        3'h4
`define CIPS_SRC_UNK        3'h5
`define CIPS_SRC_NSTD       3'h6
`define CIPS_SRC_OTG        3'h7
`define CIPS_CTRL_RST       8'h24

`endif

//--- design/cips_pkg.sv
// Types for the charger input power-up sequencer
`default_nettype none
package cips_pkg;
   // Input-side power-up sequence
   typedef enum logic [2:0] {
      CIPS_HIZ, CIPS_QUAL, CIPS_RETRY, CIPS_DETECT, CIPS_RUN, CIPS_BOOST
   } cips_state_t;
   // BC1.2 result from the analog detector
   typedef enum logic [2:0] {
      CIPS_BC_SDP, CIPS_BC_CDP, CIPS_BC_DCP, CIPS_BC_DIV1,
      CIPS_BC_DIV2, CIPS_BC_DIV3, CIPS_BC_DIV4, CIPS_BC_UNK
   } cips_bc_t;
endpackage : cips_pkg
`default_nettype wire

//--- design/cips_seq.sv
// Charger input power-up and boost entry sequencer
//
// Implementation choices: the register offsets and the address-and-strobe port.
`include "cips_cfg.svh"
`default_nettype none
module cips_seq #(
   parameter int unsigned CYC_INTERNAL_BIAS_REGULATOR  = `CIPS_CYC_INTERNAL_BIAS_REGULATOR,
   parameter int unsigned CYC_QUAL  = `CIPS_CYC_QUAL,
   parameter int unsigned CYC_RETRY = `CIPS_CYC_RETRY,
   parameter int unsigned CYC_OTG   = `CIPS_CYC_OTG,
   parameter int unsigned CYC_PFM   = `CIPS_CYC_PFM,
   parameter bit          USE_BC12  = 1'b1
) (
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   // Register port
   input  wire logic [3:0]       addr_in,
   input  wire logic [7:0]       wdata_in,
   input  wire logic             wr_in,
   input  wire logic             rd_in,
   output logic      [7:0]       rdata_out,
   // Comparator flags
   input  wire logic             vin_present_in,
   input  wire logic             vin_awake_in,
   input  wire logic             vin_sleep_in,
   input  wire logic             vin_ov_in,
   input  wire logic             vin_min_in,
   input  wire logic             bat_otg_ok_in,
   input  wire logic             ts_ok_in,
   input  wire logic             sys_low_in,
   input  wire logic             bat_below_min_in,
   input  wire logic             select_pin_in,
   // BC1.2 analog detector handshake
   input  wire logic             bc_done_in,
   input  wire cips_pkg::cips_bc_t bc_result_in,
   output logic                  bc_run_out,
   // Analog controls
   output logic                  regulator_on_out,
   output logic                  test_load_out,
   output logic                  converter_on_out,
   output logic                  boost_on_out,
   output logic                  light_load_out,
   output logic                  battery_switch_out,
   output logic                  boost_2a_out,
   output logic [4:0]            ilim_eff_out,
   output logic [3:0]            vlim_out,
   output logic [1:0]            vlim_os_out,
   output logic                  vtrack_on_out,
   output logic [1:0]            vtrack_sel_out,
   output logic [1:0]            dplus_drive_out,
   output logic [1:0]            dminus_drive_out,
   output logic                  host_alert_pulse_out
);
   import cips_pkg::*;

   initial begin
      if (CYC_INTERNAL_BIAS_REGULATOR == 0 || CYC_QUAL == 0 || CYC_RETRY == 0 || CYC_OTG == 0 || CYC_PFM == 0)
         $error("timing counts must be nonzero");
   end

   // ==============================
   // Input synchronisers
   localparam int NSYNC = 11;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1_ff, sync2_ff;
   logic             done_q_ff;
   assign raw_in = {vin_present_in, vin_awake_in, vin_sleep_in, vin_ov_in, vin_min_in,
                    bat_otg_ok_in, ts_ok_in, sys_low_in, bat_below_min_in,
                    select_pin_in, bc_done_in};

   // Two-stage catch of every comparator flag
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
      end
   end

   logic s_present, s_awake, s_sleep, s_ov, s_min, s_batok, s_ts, s_syslow;
   logic s_batlow, s_sel, s_done;
   assign {s_present, s_awake, s_sleep, s_ov, s_min, s_batok, s_ts, s_syslow,
           s_batlow, s_sel, s_done} = sync2_ff;

   // ==============================
   // Functions
   // BC1.2 result to current code and source type
   function automatic logic [7:0] bc_map(input cips_bc_t r);
      unique case (r)
         CIPS_BC_SDP:  bc_map = {`CIPS_SRC_SDP,  `CIPS_ILIM_500MA};
         CIPS_BC_CDP:  bc_map = {`CIPS_SRC_CDP,  `CIPS_ILIM_1500MA};
         CIPS_BC_DCP:  bc_map = {`CIPS_SRC_DCP,  `CIPS_ILIM_2400MA};
         CIPS_BC_DIV1: bc_map = {`CIPS_SRC_NSTD, `CIPS_ILIM_2100MA};
         CIPS_BC_DIV2: bc_map = {`CIPS_SRC_NSTD, `CIPS_ILIM_2000MA};
         CIPS_BC_DIV3: bc_map = {`CIPS_SRC_NSTD, `CIPS_ILIM_1000MA};
         CIPS_BC_DIV4: bc_map = {`CIPS_SRC_NSTD, `CIPS_ILIM_2400MA};
         CIPS_BC_UNK:  bc_map = {`CIPS_SRC_UNK,  `CIPS_ILIM_500MA};
      endcase
   endfunction : bc_map

   // Select pin level to current code and source type
   function automatic logic [7:0] pin_map(input logic hi);
      pin_map = hi ? {`CIPS_SRC_SDP, `CIPS_ILIM_500MA}
                   : {`CIPS_SRC_ADAPT, `CIPS_ILIM_2400MA};
   endfunction : pin_map

   // ==============================
   // State
   cips_state_t state_ff, nxt_state;
   logic [31:0] cnt_ff, nxt_cnt;
   logic [31:0] otg_cnt_ff, nxt_otg_cnt;
   logic [31:0] pfm_cnt_ff, nxt_pfm_cnt;
   logic [7:0]  ctrl_ff, nxt_ctrl;
   logic [3:0]  vlim_ff, nxt_vlim;
   logic [1:0]  vos_ff, nxt_vos;
   logic [1:0]  vtrk_ff, nxt_vtrk;
   logic [4:0]  ilim_ff, nxt_ilim;
   logic [1:0]  dp_ff, nxt_dp, dm_ff, nxt_dm;
   logic [2:0]  src_ff, nxt_src;
   logic        good_ff, nxt_good, pg_ff, nxt_pg;
   logic        alert_ff, nxt_alert;
   logic        bcrun_ff, nxt_bcrun;
   logic [7:0]  rdata_ff, nxt_rdata;
   logic        det_done;
   logic [7:0]  det_res;

   // Detection finishes on the BC1.2 done edge, or at once for the pin
   assign det_done = USE_BC12 ? (s_done && !done_q_ff && bcrun_ff) : 1'b1;
   assign det_res  = USE_BC12 ? bc_map(bc_result_in) : pin_map(s_sel);

   // Next-state: sequence, timers and register writes
   always_comb begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_otg_cnt = otg_cnt_ff;
      nxt_pfm_cnt = pfm_cnt_ff;
      nxt_ctrl    = ctrl_ff;
      nxt_vlim    = vlim_ff;
      nxt_vos     = vos_ff;
      nxt_vtrk    = vtrk_ff;
      nxt_ilim    = ilim_ff;
      nxt_dp      = dp_ff;
      nxt_dm      = dm_ff;
      nxt_src     = src_ff;
      nxt_good    = good_ff;
      nxt_pg      = pg_ff;
      nxt_alert   = 1'b0;
      nxt_bcrun   = 1'b0;
      nxt_rdata   = 8'h00;
      // Software writes first, so hardware updates below win
      if (wr_in) begin
         unique case (addr_in)
            `CIPS_ADDR_CTRL: nxt_ctrl = wdata_in;
            `CIPS_ADDR_VLIM: begin
               nxt_vlim = wdata_in[3:0];
               nxt_vos  = wdata_in[5:4];
               nxt_vtrk = wdata_in[7:6];
            end
            `CIPS_ADDR_ILIM: nxt_ilim = wdata_in[4:0];
            `CIPS_ADDR_DPDM: begin
               nxt_dp = wdata_in[1:0];
               nxt_dm = wdata_in[3:2];
            end
            default: ;
         endcase
      end
      if (rd_in) begin
         unique case (addr_in)
            `CIPS_ADDR_CTRL: nxt_rdata = ctrl_ff;
            `CIPS_ADDR_VLIM: nxt_rdata = {vtrk_ff, vos_ff, vlim_ff};
            `CIPS_ADDR_ILIM: nxt_rdata = {3'h0, ilim_ff};
            `CIPS_ADDR_DPDM: nxt_rdata = {4'h0, dm_ff, dp_ff};
            `CIPS_ADDR_STAT: nxt_rdata = {pg_ff, good_ff, 1'b0, src_ff, state_ff[1:0]};
            `CIPS_ADDR_VEFF: nxt_rdata = {3'h0, ilim_eff_out};
            default:         nxt_rdata = 8'h00;
         endcase
      end
      // OTG enable must have stood for 30ms
      if (!ctrl_ff[`CIPS_B_OTGEN])
         nxt_otg_cnt = '0;
      else if (otg_cnt_ff < CYC_OTG)
         nxt_otg_cnt = otg_cnt_ff + 32'd1;
      if (state_ff != CIPS_BOOST)
         nxt_pfm_cnt = '0;
      else if (pfm_cnt_ff < CYC_PFM)
         nxt_pfm_cnt = pfm_cnt_ff + 32'd1;

      unique case (state_ff)
         CIPS_HIZ: begin
            if (s_present && s_awake) begin
               nxt_cnt = cnt_ff + 32'd1;
               if (cnt_ff + 32'd1 >= CYC_INTERNAL_BIAS_REGULATOR) begin
                  nxt_state = CIPS_QUAL;
                  nxt_cnt   = '0;
               end
            end else begin
               nxt_cnt = '0;
               if (otg_cnt_ff >= CYC_OTG && s_batok && s_sleep && s_ts)
                  nxt_state = CIPS_BOOST;
            end
         end
         CIPS_QUAL: begin
            nxt_cnt = cnt_ff + 32'd1;
            if (s_ov || !s_min) begin
               nxt_state = CIPS_RETRY;
               nxt_cnt   = '0;
            end else if (cnt_ff + 32'd1 >= CYC_QUAL) begin
               nxt_state = CIPS_DETECT;
               nxt_good  = 1'b1;
               nxt_alert = 1'b1;
               nxt_cnt   = '0;
            end
         end
         CIPS_RETRY: begin
            nxt_cnt = cnt_ff + 32'd1;
            if (cnt_ff + 32'd1 >= CYC_RETRY) begin
               nxt_state = CIPS_QUAL;
               nxt_cnt   = '0;
            end
         end
         CIPS_DETECT: begin
            nxt_bcrun = USE_BC12 && !det_done;
            if (det_done) begin
               nxt_ilim  = det_res[4:0];
               nxt_src   = det_res[7:5];
               nxt_pg    = 1'b1;
               nxt_alert = 1'b1;
               nxt_state = CIPS_RUN;
            end
         end
         CIPS_RUN: begin
            // Pin tracked live only in default mode
            if (!USE_BC12 && !ctrl_ff[`CIPS_B_HOSTMODE]) begin
               nxt_ilim = det_res[4:0];
               nxt_src  = det_res[7:5];
            end
            if (ctrl_ff[`CIPS_B_FORCEDET] && ctrl_ff[`CIPS_B_HOSTMODE])
               nxt_state = CIPS_DETECT;
         end
         CIPS_BOOST: begin
            nxt_src = `CIPS_SRC_OTG;
            if (!ctrl_ff[`CIPS_B_OTGEN] || !s_batok)
               nxt_state = CIPS_HIZ;
         end
         default: nxt_state = CIPS_HIZ;
      endcase
      // Force bit drops itself once detection completes
      if (state_ff == CIPS_DETECT && det_done)
         nxt_ctrl[`CIPS_B_FORCEDET] = 1'b0;
      // Input gone: back to high impedance, status lost
      if (state_ff != CIPS_HIZ && state_ff != CIPS_BOOST && !(s_present && s_awake)) begin
         nxt_state = CIPS_HIZ;
         nxt_cnt   = '0;
         nxt_good  = 1'b0;
         nxt_pg    = 1'b0;
         nxt_src   = `CIPS_SRC_NONE;
      end
      if (state_ff == CIPS_BOOST && nxt_state == CIPS_HIZ)
         nxt_src = `CIPS_SRC_NONE;
   end

   // State registers
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_ff   <= CIPS_HIZ;
         cnt_ff     <= '0;
         otg_cnt_ff <= '0;
         pfm_cnt_ff <= '0;
         ctrl_ff    <= `CIPS_CTRL_RST;
         vlim_ff    <= `CIPS_VLIM_RST;
         vos_ff     <= `CIPS_VOS_RST;
         vtrk_ff    <= 2'h0;
         ilim_ff    <= `CIPS_ILIM_500MA;
         dp_ff      <= 2'h0;
         dm_ff      <= 2'h0;
         src_ff     <= `CIPS_SRC_NONE;
         good_ff    <= 1'b0;
         pg_ff      <= 1'b0;
         alert_ff   <= 1'b0;
         bcrun_ff   <= 1'b0;
         rdata_ff   <= 8'h00;
         done_q_ff  <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         otg_cnt_ff <= nxt_otg_cnt;
         pfm_cnt_ff <= nxt_pfm_cnt;
         ctrl_ff    <= nxt_ctrl;
         vlim_ff    <= nxt_vlim;
         vos_ff     <= nxt_vos;
         vtrk_ff    <= nxt_vtrk;
         ilim_ff    <= nxt_ilim;
         dp_ff      <= nxt_dp;
         dm_ff      <= nxt_dm;
         src_ff     <= nxt_src;
         good_ff    <= nxt_good;
         pg_ff      <= nxt_pg;
         alert_ff   <= nxt_alert;
         bcrun_ff   <= nxt_bcrun;
         rdata_ff   <= nxt_rdata;
         done_q_ff  <= s_done;
      end
   end

   // ==============================
   // Analog control outputs, registered apart from the three state decodes (regulator, test load, boost)
   logic [4:0] nxt_ilim_eff;
   logic       nxt_light, nxt_conv, nxt_bsw, nxt_trk;
   logic [1:0] nxt_dpo, nxt_dmo;
   logic [4:0] ilim_eff_ff;
   logic       light_ff, conv_ff, bsw_ff, trk_ff;
   logic [1:0] dpo_ff, dmo_ff;

   // Output drive: converter, limits, light-load and line drives
   always_comb begin
      nxt_conv = (nxt_state == CIPS_RUN);
      // Soft-start cap while system rail is low
      if (s_syslow && nxt_ilim > `CIPS_ILIM_200MA)
         nxt_ilim_eff = `CIPS_ILIM_200MA;
      else
         nxt_ilim_eff = nxt_ilim;
      nxt_bsw = nxt_conv ? nxt_ctrl[`CIPS_B_CHGEN] : 1'b1;
      if (nxt_ctrl[`CIPS_B_PFMBLK])
         nxt_light = 1'b0;
      else if (nxt_state == CIPS_BOOST)
         nxt_light = (nxt_pfm_cnt < CYC_PFM);
      else
         nxt_light = nxt_conv && (!nxt_ctrl[`CIPS_B_CHGEN] || s_batlow);
      // Tracking only counts with zero offset field
      nxt_trk = (nxt_vtrk != 2'h0) && (nxt_vos == 2'h0);
      // Host line settings masked while BC1.2 owns the lines
      nxt_dpo = nxt_bcrun ? 2'h0 : nxt_dp;
      nxt_dmo = nxt_bcrun ? 2'h0 : nxt_dm;
   end

   // Output registers
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ilim_eff_ff <= 5'h00;
         light_ff    <= 1'b0;
         conv_ff     <= 1'b0;
         bsw_ff      <= 1'b1;
         trk_ff      <= 1'b0;
         dpo_ff      <= 2'h0;
         dmo_ff      <= 2'h0;
      end else begin
         ilim_eff_ff <= nxt_ilim_eff;
         light_ff    <= nxt_light;
         conv_ff     <= nxt_conv;
         bsw_ff      <= nxt_bsw;
         trk_ff      <= nxt_trk;
         dpo_ff      <= nxt_dpo;
         dmo_ff      <= nxt_dmo;
      end
   end

   // Register-backed outputs, with regulator, test load and boost decoded from the state
   assign rdata_out            = rdata_ff;
   assign host_alert_pulse_out = alert_ff;
   assign bc_run_out           = bcrun_ff;
   assign regulator_on_out     = !(state_ff inside {CIPS_HIZ, CIPS_BOOST});
   assign test_load_out        = (state_ff == CIPS_QUAL);
   assign converter_on_out     = conv_ff;
   assign boost_on_out         = (state_ff == CIPS_BOOST);
   assign light_load_out       = light_ff;
   assign battery_switch_out   = bsw_ff;
   assign boost_2a_out         = ctrl_ff[`CIPS_B_BOOSTSEL];
   assign ilim_eff_out         = ilim_eff_ff;
   assign vlim_out             = vlim_ff;
   assign vlim_os_out          = vos_ff;
   assign vtrack_on_out        = trk_ff;
   assign vtrack_sel_out       = vtrk_ff;
   assign dplus_drive_out      = dpo_ff;
   assign dminus_drive_out     = dmo_ff;
endmodule : cips_seq
`default_nettype wire
